// ### core/asci_top.v
// serial command decoder, channel configuration and result shifter
//
// Overview of operation
// - strobe goes high when result ready
// - strobe stays low in external clock mode
// - strobe always driven, never floated
// - single-ended zero range starts conversion in modes 0-2 only
// - differential zero range is mode control
// - single-ended codes 1-6 select six ranges
// - code 7 is default bipolar six-span
// - differential codes 1,4,7 valid, others reserved
// - start bit is first high with select low
// - start allowed when idle and result read
// - early start after 13, 9, 12 bits
// - result MSB first on falling edges
// - result is sixteen bits wide
// - one configuration register per input
// - one eight-bit mode register
// - conversion only on start byte, current method
// - internal clock sets mode 2 sampling
// - mode field decode with two reserved codes
// - sample rising, drive falling, float when deselected
// - reset code restores mode and channel defaults
`timescale 1ns/100ps
`include "asci_map.vh"
module asci_top #(
    parameter NCH = 8,
    parameter [7:0] CONV0_SCLKS = 8'h10,
    parameter CONV_ICLKS = 17
) (
    input wire ref_clk,
    input wire rst_b,
    input wire sclk,
    input wire cs_b,
    input wire din,
    output wire dout_o,
    output wire dout_oe_b,
    output reg conversion_done_strobe,
    input wire [`ASCI_RES_W-1:0] adc_code,
    output wire sample_strobe,
    output wire conv_busy,
    output reg [2:0] conv_channel,
    output reg conv_differential,
    output reg [2:0] conv_range,
    output wire [2:0] mode_code,
    output wire partial_power_down,
    output wire full_power_down,
    output wire [NCH-1:0] chan_differential_select,
    output wire [3*NCH-1:0] chan_range_code
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CMD = 2'h1;
    localparam [1:0] ST_ACQ = 2'h2;
    localparam [1:0] ST_INT = 2'h3;
    localparam [7:0] DONE_FALL_M0 = `ASCI_SAMPLE_FALL_M0 + CONV0_SCLKS;

    reg rst_m_q;
    reg rst_n_q;
    wire s_sclk;
    wire s_cs_b;
    wire s_din;
    reg sclk_p_q;
    reg cs_p_q;
    reg [1:0] st_q;
    reg [2:0] bit_q;
    reg [6:0] sr_q;
    reg [7:0] fcnt_q;
    reg [7:0] mode_q;
    reg [2:0] cmode_q;
    reg [`ASCI_RES_W-1:0] osr_q;
    reg [4:0] rd_q;
    reg samp_q;
    wire [4*NCH-1:0] cfg_flat;
    wire rise;
    wire fall;
    wire [7:0] fcnt_n;
    wire [7:0] cmd_byte;
    wire byte_done;
    wire [2:0] cmd_m;
    wire [2:0] cmd_rng;
    wire cmd_dif;
    wire is_start;
    wire is_mode;
    reg [4:0] early_thr;
    wire start_ok;
    wire start_bit;
    reg go_start;
    reg mode_we;
    reg cfg_rst;
    reg cfg_we;
    reg int_go;
    reg int_skip;
    wire int_samp;
    wire int_done;
    wire int_busy;

    // reset release through two flops
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    asci_sync #(
        .W(3),
        .RST_VAL(3'h2)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .d({sclk, cs_b, din}),
        .q({s_sclk, s_cs_b, s_din})
    );

    asci_conv #(
        .CONV_ICLKS(CONV_ICLKS)
    ) u_conv (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .go(int_go),
        .skip_acq(int_skip),
        .sample_pulse(int_samp),
        .done(int_done),
        .busy(int_busy)
    );

    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sclk_p_q <= 1'b0;
            cs_p_q <= 1'b1;
        end else begin
            sclk_p_q <= s_sclk;
            cs_p_q <= s_cs_b;
        end
    end

    // edges only count with select low
    assign rise = s_sclk & ~sclk_p_q & ~s_cs_b;
    assign fall = ~s_sclk & sclk_p_q & ~cs_p_q;
    assign fcnt_n = fcnt_q + 8'h01;

    assign cmd_byte = {sr_q, s_din};
    assign byte_done = rise && (st_q == ST_CMD) && (bit_q == `ASCI_CMD_LAST_BIT);
    assign cmd_m = cmd_byte[`ASCI_CH_HI:`ASCI_CH_LO];
    assign cmd_dif = cmd_byte[`ASCI_DIF_POS];
    assign cmd_rng = cmd_byte[`ASCI_RNG_HI:`ASCI_RNG_LO];
    assign is_start = (cmd_byte[3:0] == `ASCI_LOW_START);
    // zero range with differential is mode byte
    assign is_mode = (cmd_byte[3:0] == `ASCI_LOW_MODE);

    always @* begin
        case (mode_q[6:4])
            `ASCI_MODE_EXT_CLK: early_thr = `ASCI_EARLY_M0;
            `ASCI_MODE_EXT_ACQ: early_thr = `ASCI_EARLY_M1;
            `ASCI_MODE_INT_CLK: early_thr = `ASCI_EARLY_M2;
            default: early_thr = `ASCI_RD_ALL;
        endcase
    end

    // idle and previous result read out
    assign start_ok = (st_q == ST_IDLE) && !int_busy && (rd_q >= early_thr);
    assign start_bit = rise && s_din && start_ok;

    always @* begin
        go_start = 1'b0;
        mode_we = 1'b0;
        cfg_rst = 1'b0;
        cfg_we = 1'b0;
        if (byte_done) begin
            if (is_start) begin
                go_start = (mode_q[6:4] == `ASCI_MODE_EXT_CLK) ||
                           (mode_q[6:4] == `ASCI_MODE_EXT_ACQ) ||
                           (mode_q[6:4] == `ASCI_MODE_INT_CLK);
            end else if (is_mode) begin
                case (cmd_m)
                    `ASCI_MODE_RESET: cfg_rst = 1'b1;
                    `ASCI_MODE_RSVD_A: mode_we = 1'b0;
                    `ASCI_MODE_RSVD_B: mode_we = 1'b0;
                    default: mode_we = 1'b1;
                endcase
            end else if (!cmd_dif) begin
                cfg_we = 1'b1;
            end else begin
                cfg_we = (cmd_rng == `ASCI_DRNG_LOW) || (cmd_rng == `ASCI_DRNG_MID) ||
                         (cmd_rng == `ASCI_DRNG_HIGH);
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_cfg
            localparam [31:0] IDX_W = gi;
            localparam [2:0] IDX = IDX_W[2:0];
            reg [3:0] cfg_q;
            always @(posedge ref_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    cfg_q <= `ASCI_CFG_RST_VAL;
                end else if (cfg_rst) begin
                    cfg_q <= `ASCI_CFG_RST_VAL;
                end else if (cfg_we && (cmd_m == IDX)) begin
                    cfg_q <= cmd_byte[3:0];
                end
            end
            assign cfg_flat[4*gi+3:4*gi] = cfg_q;
            assign chan_differential_select[gi] = cfg_q[3];
            assign chan_range_code[3*gi+2:3*gi] = cfg_q[2:0];
        end
    endgenerate

    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= `ASCI_MODE_RST_VAL;
        end else if (cfg_rst) begin
            mode_q <= `ASCI_MODE_RST_VAL;
        end else if (mode_we) begin
            mode_q <= cmd_byte;
        end
    end

    assign mode_code = mode_q[6:4];
    assign partial_power_down = (mode_q[6:4] == `ASCI_MODE_PART_PD);
    assign full_power_down = (mode_q[6:4] == `ASCI_MODE_FULL_PD);
    assign conv_busy = (st_q == ST_ACQ) || (st_q == ST_INT);
    assign sample_strobe = samp_q | int_samp;

    // command framing and conversion sequencing
    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= ST_IDLE;
            bit_q <= 3'h0;
            sr_q <= 7'h00;
            fcnt_q <= 8'h00;
            cmode_q <= `ASCI_MODE_EXT_CLK;
            samp_q <= 1'b0;
            int_go <= 1'b0;
            int_skip <= 1'b0;
            conv_channel <= 3'h0;
            conv_differential <= 1'b0;
            conv_range <= 3'h0;
        end else begin
            samp_q <= 1'b0;
            int_go <= 1'b0;
            if (st_q != ST_IDLE && fall) begin
                fcnt_q <= fcnt_n;
            end
            case (st_q)
                ST_IDLE: begin
                    if (start_bit) begin
                        st_q <= ST_CMD;
                        bit_q <= 3'h1;
                        sr_q <= 7'h01;
                        fcnt_q <= 8'h00;
                    end
                end
                ST_CMD: begin
                    if (s_cs_b) begin
                        st_q <= ST_IDLE;
                    end else if (rise) begin
                        sr_q <= cmd_byte[6:0];
                        bit_q <= bit_q + 3'h1;
                        if (byte_done) begin
                            st_q <= go_start ? ST_ACQ : ST_IDLE;
                            cmode_q <= mode_q[6:4];
                            conv_channel <= cmd_m;
                            conv_differential <= cfg_flat[4*cmd_m+3];
                            conv_range <= cfg_flat[4*cmd_m+:3];
                        end
                    end
                end
                ST_ACQ: begin
                    if (fall) begin
                        case (cmode_q)
                            `ASCI_MODE_EXT_CLK: begin
                                if (fcnt_n == `ASCI_SAMPLE_FALL_M0) begin
                                    samp_q <= 1'b1;
                                end
                                // conversion clocked by the link clock
                                if (fcnt_n == DONE_FALL_M0) begin
                                    st_q <= ST_IDLE;
                                end
                            end
                            `ASCI_MODE_EXT_ACQ: begin
                                // sample on sixteenth fall, then internal
                                if (fcnt_n == `ASCI_SAMPLE_FALL_M1) begin
                                    samp_q <= 1'b1;
                                    int_go <= 1'b1;
                                    int_skip <= 1'b1;
                                    st_q <= ST_INT;
                                end
                            end
                            default: begin
                                if (fcnt_n == `ASCI_GO_FALL_M2) begin
                                    int_go <= 1'b1;
                                    int_skip <= 1'b0;
                                    st_q <= ST_INT;
                                end
                            end
                        endcase
                    end
                end
                ST_INT: begin
                    if (int_done) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // result shifter and read-out counter
    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osr_q <= {`ASCI_RES_W{1'b0}};
            rd_q <= `ASCI_RD_ALL;
        end else if ((st_q == ST_ACQ) && fall && (cmode_q == `ASCI_MODE_EXT_CLK) &&
                     (fcnt_n == DONE_FALL_M0)) begin
            osr_q <= adc_code;
            rd_q <= 5'h00;
        end else if ((st_q == ST_INT) && int_done) begin
            osr_q <= adc_code;
            rd_q <= 5'h00;
        end else begin
            if (go_start) begin
                rd_q <= `ASCI_RD_ALL;
            end else if (rise && (rd_q != `ASCI_RD_ALL)) begin
                rd_q <= rd_q + 5'h01;
            end
            // next bit on each falling edge
            if (fall) begin
                osr_q <= {osr_q[`ASCI_RES_W-2:0], 1'b0};
            end
        end
    end

    assign dout_o = osr_q[`ASCI_RES_W-1];
    assign dout_oe_b = s_cs_b;

    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conversion_done_strobe <= 1'b0;
        end else if ((st_q == ST_INT) && int_done) begin
            conversion_done_strobe <= 1'b1;
        end else if (start_bit || cfg_rst) begin
            conversion_done_strobe <= 1'b0;
        end else if (mode_q[6:4] == `ASCI_MODE_EXT_CLK) begin
            conversion_done_strobe <= 1'b0;
        end
    end
endmodule // asci_top

// ### core/asci_map.vh
// constants of the serial command interface: fields, codes, resets, timing
`ifndef ASCI_MAP_VH
`define ASCI_MAP_VH

`define ASCI_RES_W 16
`define ASCI_CH_HI 6
`define ASCI_CH_LO 4
`define ASCI_DIF_POS 3
`define ASCI_RNG_HI 2
`define ASCI_RNG_LO 0

`define ASCI_LOW_START 4'h0
`define ASCI_LOW_MODE 4'h8

`define ASCI_MODE_EXT_CLK 3'h0
`define ASCI_MODE_EXT_ACQ 3'h1
`define ASCI_MODE_INT_CLK 3'h2
`define ASCI_MODE_RSVD_A 3'h3
`define ASCI_MODE_RESET 3'h4
`define ASCI_MODE_RSVD_B 3'h5
`define ASCI_MODE_PART_PD 3'h6
`define ASCI_MODE_FULL_PD 3'h7
`define ASCI_MODE_RST_VAL 8'h88

`define ASCI_CFG_RST_VAL 4'h7
`define ASCI_DRNG_LOW 3'h1
`define ASCI_DRNG_MID 3'h4
`define ASCI_DRNG_HIGH 3'h7

`define ASCI_RD_ALL 5'h10
`define ASCI_EARLY_M0 5'h0D
`define ASCI_EARLY_M1 5'h09
`define ASCI_EARLY_M2 5'h0C

`define ASCI_CMD_LAST_BIT 3'h7
`define ASCI_SAMPLE_FALL_M0 8'h0E
`define ASCI_SAMPLE_FALL_M1 8'h10
`define ASCI_GO_FALL_M2 8'h08

`define ASCI_REF_CLK_NS 10
`define ASCI_ICLK_START_NS 100
`define ASCI_ICLK_PERIOD_NS 222
`define ASCI_SAMPLE_ICLKS 11
`define ASCI_ICLK_START_CYC ((`ASCI_ICLK_START_NS + `ASCI_REF_CLK_NS - 1) / `ASCI_REF_CLK_NS)
`define ASCI_ICLK_CYC (`ASCI_ICLK_PERIOD_NS / `ASCI_REF_CLK_NS)
`define ASCI_SAMPLE_CYC (`ASCI_ICLK_START_CYC + `ASCI_SAMPLE_ICLKS * `ASCI_ICLK_CYC)

`endif

// ### core/asci_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module asci_sync #(
    parameter W = 3,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] m_q;
    reg [W-1:0] s_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_q <= RST_VAL;
            s_q <= RST_VAL;
        end else begin
            m_q <= d;
            s_q <= m_q;
        end
    end

    assign q = s_q;
endmodule // asci_sync

// ### core/asci_conv.v
// internally timed acquisition and conversion sequencer
`timescale 1ns/100ps
`include "asci_map.vh"
module asci_conv #(
    parameter CONV_ICLKS = 17
) (
    input wire clk,
    input wire rst_n,
    input wire go,
    input wire skip_acq,
    output reg sample_pulse,
    output reg done,
    output reg busy
);
    localparam integer CONV_CYC = CONV_ICLKS * `ASCI_ICLK_CYC;
    localparam integer SAMP_LAST_I = `ASCI_SAMPLE_CYC - 1;
    localparam integer CONV_LAST_I = CONV_CYC - 1;
    localparam [11:0] SAMP_LAST = SAMP_LAST_I[11:0];
    localparam [11:0] CONV_LAST = CONV_LAST_I[11:0];

    reg acq_q;
    reg [11:0] cnt_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acq_q <= 1'b0;
            cnt_q <= 12'h000;
            busy <= 1'b0;
            done <= 1'b0;
            sample_pulse <= 1'b0;
        end else begin
            done <= 1'b0;
            sample_pulse <= 1'b0;
            if (go) begin
                busy <= 1'b1;
                acq_q <= ~skip_acq;
                cnt_q <= 12'h000;
            end else if (busy) begin
                if (acq_q) begin
                    // internal clock picks the sampling instant
                    if (cnt_q == SAMP_LAST) begin
                        acq_q <= 1'b0;
                        cnt_q <= 12'h000;
                        sample_pulse <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end else if (cnt_q == CONV_LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 12'h001;
                end
            end
        end
    end
endmodule // asci_conv

// ### tb/asci_top_sva.sv
// assertion checker for the serial command interface ports
`timescale 1ns/100ps
module asci_top_sva #(
    parameter NCH = 8
) (
    input wire ref_clk,
    input wire rst_b,
    input wire sclk,
    input wire cs_b,
    input wire dout_o,
    input wire dout_oe_b,
    input wire conversion_done_strobe,
    input wire sample_strobe,
    input wire conv_busy,
    input wire [2:0] conv_channel,
    input wire conv_differential,
    input wire [2:0] conv_range,
    input wire [2:0] mode_code,
    input wire partial_power_down,
    input wire full_power_down,
    input wire [NCH-1:0] chan_differential_select,
    input wire [3*NCH-1:0] chan_range_code
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    a_strobe_on_done: assert property (
        $rose(conversion_done_strobe) |-> (mode_code == 3'h1 || mode_code == 3'h2)
        && $past(conv_busy, 2)) else $error("strobe rose without a conversion");
    a_ext_strobe_low: assert property (
        $past(mode_code) == 3'h0 |-> !conversion_done_strobe)
        else $error("strobe high in external clock mode");
    a_oe_follows_cs: assert property (
        $stable(cs_b) [*4] |-> dout_oe_b == cs_b) else $error("output enable off select");
    a_dout_on_fall: assert property (
        $changed(dout_o) |-> !$past(sclk, 3)) else $error("serial output moved off a fall");
    a_reset_defaults: assert property (
        $rose(rst_b) |-> chan_range_code == {NCH{3'h7}} && chan_differential_select == 0
        && mode_code == 3'h0 && !conversion_done_strobe) else $error("reset defaults wrong");
    a_mode_legal: assert property (
        $changed(mode_code) |-> !(mode_code inside {3'h3, 3'h4, 3'h5}))
        else $error("mode register took an illegal code");
    a_sample_in_conv: assert property (
        sample_strobe |-> $past(conv_busy) && conv_busy) else $error("sample outside a conversion");
    a_sample_one_cycle: assert property (
        sample_strobe |=> !sample_strobe) else $error("sample pulse longer than a cycle");
    a_power_decode: assert property (
        partial_power_down == (mode_code == 3'h6) && full_power_down == (mode_code == 3'h7))
        else $error("power state decode wrong");
    a_conv_cfg: assert property (
        $rose(conv_busy) |=> conv_range == chan_range_code[3*conv_channel +: 3]
        && conv_differential == chan_differential_select[conv_channel])
        else $error("conversion setup differs from channel setting");
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            a_diff_range_legal: assert property (
                chan_differential_select[g] |-> chan_range_code[3*g +: 3] inside
                {3'h1, 3'h4, 3'h7}) else $error("reserved differential range stored");
        end
    endgenerate
endmodule // asci_top_sva

bind asci_top asci_top_sva #(.NCH(NCH)) i_asci_top_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dout_o(dout_o),
    .dout_oe_b(dout_oe_b), .conversion_done_strobe(conversion_done_strobe),
    .sample_strobe(sample_strobe),
    .conv_busy(conv_busy), .conv_channel(conv_channel),
    .conv_differential(conv_differential), .conv_range(conv_range),
    .mode_code(mode_code), .partial_power_down(partial_power_down),
    .full_power_down(full_power_down), .chan_differential_select(chan_differential_select),
    .chan_range_code(chan_range_code)
);

// ### tb/asci_master.sv
// serial bus master model driving the command link
`timescale 1ns/100ps
module asci_master #(
    parameter C0 = 4
) (
    input wire ref_clk,
    input wire dout_o,
    input wire dout_oe_b,
    input wire conversion_done_strobe,
    output reg sclk,
    output reg cs_b,
    output reg din
);
    reg sdo_last = 1'b0;
    reg [63:0] rx;
    wire sdo;
    // released line shows the inverse of its last level
    assign sdo = dout_oe_b ? ~sdo_last : dout_o;
    always @(posedge ref_clk) begin
        if (!dout_oe_b) begin
            sdo_last <= dout_o;
        end
    end
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        din = 1'b0;
    end
    task wt(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task sel(input lvl);
        begin
            wt(4);
            cs_b = lvl;
            wt(4);
        end
    endtask
    task xfer(input [63:0] tx, input integer n, output [63:0] got);
        integer i;
        begin
            got = 64'h0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                din = tx[i];
                wt(4);
                sclk = 1'b1;
                wt(4);
                got = {got[62:0], sdo};
                sclk = 1'b0;
            end
            din = 1'b0;
        end
    endtask
    task conv(input [2:0] m, input [2:0] ch, output [15:0] res);
        integer n;
        begin
            n = (m == 3'h0) ? 30 + C0 : (m == 3'h1) ? 16 : 8;
            sel(1'b0);
            xfer({56'h0, 1'b1, ch, 4'h0} << (n - 8), n, rx);
            if (m != 3'h0) begin
                sel(1'b1);
                for (n = 0; n < 1000 && !conversion_done_strobe; n = n + 1)
                    wt(1);
                sel(1'b0);
                xfer(64'h0, 16, rx);
            end
            sel(1'b1);
            res = rx[15:0];
        end
    endtask
endmodule // asci_master

// ### tb/asci_top_tb.sv
// self-checking bench for the serial command interface
`timescale 1ns/100ps
module asci_top_tb;
    localparam integer NCH = 8;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [15:0] adc_code = 16'h0000;
    wire sclk, cs_b, din, dout_o, dout_oe_b, conversion_done_strobe;
    wire [2:0] conv_channel, mode_code;
    wire [NCH-1:0] chan_differential_select;
    wire [3*NCH-1:0] chan_range_code;
    reg [2:0] e_rng [0:NCH-1];
    reg e_dif [0:NCH-1];
    reg [2:0] e_mode, ch, m;
    reg [15:0] res;
    reg [63:0] rx;
    integer fails = 0, checks = 0, cyc = 0, i, k, r;

    asci_top #(.NCH(NCH), .CONV0_SCLKS(8'h04), .CONV_ICLKS(2)) i_asci_top (
        .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din),
        .dout_o(dout_o), .dout_oe_b(dout_oe_b),
        .conversion_done_strobe(conversion_done_strobe), .adc_code(adc_code),
        .sample_strobe(), .conv_busy(), .conv_channel(conv_channel),
        .conv_differential(), .conv_range(), .mode_code(mode_code),
        .partial_power_down(), .full_power_down(),
        .chan_differential_select(chan_differential_select),
        .chan_range_code(chan_range_code)
    );
    asci_master #(.C0(4)) i_asci_master (
        .ref_clk(ref_clk), .dout_o(dout_o), .dout_oe_b(dout_oe_b),
        .conversion_done_strobe(conversion_done_strobe),
        .sclk(sclk), .cs_b(cs_b), .din(din)
    );
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            finish_test;
        end
    end
    task finish_test;
        begin
            if (fails == 0 && checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input [8*8-1:0] what);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t: %0s got %0h exp %0h", $time, what, got, exp);
            end
        end
    endtask
    // expected effect of one command byte
    task apply(input [7:0] c);
        begin
            if (c[3:0] == 4'h8 && c[6:4] == 3'h4) begin
                e_mode = 3'h0;
                for (k = 0; k < NCH; k = k + 1) begin
                    e_rng[k] = 3'h7;
                    e_dif[k] = 1'b0;
                end
            end else if (c[3:0] == 4'h8) begin
                if (c[6:4] != 3'h3 && c[6:4] != 3'h5)
                    e_mode = c[6:4];
            end else if (c[2:0] != 3'h0 && (!c[3] || c[2:0] == 3'h1 || c[2:0] == 3'h4
                    || c[2:0] == 3'h7)) begin
                e_rng[c[6:4]] = c[2:0];
                e_dif[c[6:4]] = c[3];
            end
        end
    endtask
    task check_state;
        begin
            for (k = 0; k < NCH; k = k + 1) begin
                chk(chan_range_code[3*k +: 3], e_rng[k], "range");
                chk(chan_differential_select[k], e_dif[k], "diff");
            end
            chk(mode_code, e_mode, "mode");
        end
    endtask
    task send(input [7:0] c);
        begin
            i_asci_master.sel(1'b0);
            i_asci_master.xfer({56'h0, c}, 8, rx);
            i_asci_master.sel(1'b1);
            apply(c);
            check_state;
        end
    endtask
    initial begin
        r = $urandom(32'h4ECC);
        apply(8'hC8);
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge ref_clk);
        check_state;
        for (i = 1; i < 16; i = i + 1) begin
            r = $urandom;
            ch = {r[2:1], r[0] & ~i[3]};
            if (i != 8)
                send({1'b1, ch, i[3:0]});
        end
        // reset code first, reserved code last
        for (i = 0; i < 8; i = i + 1)
            send({1'b1, i[2:0] ^ 3'h4, 4'h8});
        i_asci_master.xfer(64'h00000000000000F1, 8, rx);
        check_state;
        for (i = 0; i < 6; i = i + 1) begin
            r = i % 3;
            m = r[2:0];
            send({1'b1, m, 4'h8});
            r = $urandom;
            adc_code = r[15:0];
            ch = r[18:16];
            i_asci_master.conv(m, ch, res);
            chk(res, adc_code, "result");
            chk(conv_channel, ch, "channel");
            chk(conversion_done_strobe, m != 3'h0, "strobe");
            check_state;
        end
        finish_test;
    end
endmodule // asci_top_tb
